/* rtl/cdr_consts.svh */
// fixed widths, limits and constants of the oversampled data recovery block
`ifndef CDR_CONSTS_SVH
`define CDR_CONSTS_SVH
`define IN_W        20
`define MAX_PICK    10
`define CNT_W       7
`define OUT_W       10
`define FIFO_DEPTH  8
`define CF_W        37
`define GAIN_W      5
`define PH_W        8
`define ACC_W       48
`define FRAC_W      32
`define ERR_W       21
`define DET_W       16
`define INTEG_W     48
`define SCAN_W      16
`define HALF_UI     40'h0080000000
`define PH_MID      8'h80
`define CF_RESET    37'h0000000000
`endif

/* rtl/cdr_pkg.sv */
// types shared by the oversampled data recovery block
package cdr_pkg;
   typedef enum logic {SCAN_IDLE, SCAN_RUN} scan_state_t;
   typedef logic signed [20:0] phase_err_t;
endpackage

/* rtl/oversampled_data_recovery.sv */
// oversampled clock and data recovery with packing buffer and eye scan
//
// Contract
// RULE1: input word width is a build-time 4, 20 or 32; partner delivers it each cycle.
// RULE2: bit 0 of each input word is the earliest sample.
// RULE3: phase detector compares transition phase against oscillator phase.
// RULE4: low-pass loop filter steers oscillator frequency to null phase error.
// RULE5: sample selector takes samples nearest each bit eye centre.
// RULE6: up to 10 picked bits per cycle, packed into lowest positions.
// RULE7: picked count shows valid picked bits each cycle.
// RULE8: barrel shifter packs bits into build-time 2..64 bit words.
// RULE9: all sub-blocks run on the single core clock.
// RULE10: datapath handles truncated rate ratio plus one bits per cycle.
// RULE11: fixed centre frequency replaces port when its enable is set.
// RULE12: each gain picks build-time constant or port by its enable.
// RULE13: sampling phase offset picks constant or port by its enable.
// RULE14: integral enable comes from port or fixed constant.
// RULE15: an option removes use of the enable input.
// RULE16: with hold allowed, tracking hold stops phase tracking.
// RULE17: extra phase count 0..2 sizes eye-scan logic.
// RULE18: per-cycle pick limit 1..64, at least the most bits per cycle.
// RULE19: separate limit bounds per-cycle eye-scan sample count.
// RULE20: precision masks trim arithmetic; all ones gives full precision.
// RULE21: eye scan runs live without disturbing recovered data.
// RULE22: rate and loop settings change at run time through ports.
// RULE23: a supplying transceiver runs in lock-to-reference mode.
// RULE24: word valid is high exactly when the output word is new; here it stays high on an unaccepted word until wordReady takes it.
// RULE25: main reset spares the integral branch; only its own reset clears it.
// RULE26: enable low freezes every process.
// RULE27: scan start is ignored while the scan is busy.
// RULE28: packed bits go earliest first into lowest word positions.
// RULE29: while held, oscillator runs at centre frequency without corrections.
`timescale 1ns/10ps
`include "cdr_consts.svh"

module stream_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 8
) (
   // clock and reset
   input  wire logic             clk,
   input  wire logic             rst,
   // fill side
   input  wire logic             inValid,
   output logic                  inReady,
   input  wire logic [WIDTH-1:0] inData,
   // drain side
   output logic                  outValid,
   input  wire logic             outReady,
   output logic [WIDTH-1:0]      outData
);
   localparam int CW = $clog2(DEPTH + 1);
   logic [WIDTH-1:0] slot [DEPTH];
   logic [CW-1:0]    fill;
   logic [CW-1:0]    next_fill;
   logic             push;
   logic             pop;
   assign inReady   = (fill != CW'(DEPTH));
   assign push      = inValid && inReady;
   assign pop       = outValid && outReady;
   assign next_fill = fill + CW'(push) - CW'(pop);
   assign outData   = slot[0];
   always_ff @(posedge clk) begin
      if (rst) begin
         fill     <= '0;
         outValid <= 1'b0;
      end else begin
         fill     <= next_fill;
         outValid <= (next_fill != '0);
      end
   end
   // shift-style storage keeps the head in a flip-flop
   for (genvar i = 0; i < DEPTH; i++) begin : g_slot
      logic [WIDTH-1:0] above;
      if (i == DEPTH - 1) begin : g_top
         assign above = '0;
      end else begin : g_mid
         assign above = slot[i+1];
      end
      always_ff @(posedge clk) begin
         if (pop) begin
            slot[i] <= (push && CW'(i) == fill - CW'(1)) ? inData : above;
         end else if (push && CW'(i) == fill) begin
            slot[i] <= inData;
         end
      end
   end
endmodule

module oversampled_data_recovery #(
   parameter logic             USE_FIXED_CENTER      = 1'b0,
   parameter logic [36:0]      FIXED_CENTER          = 37'h0000000000,
   parameter logic             USE_FIXED_DIRECT      = 1'b0,
   parameter logic [4:0]       FIXED_DIRECT_GAIN     = 5'h00,
   parameter logic             USE_FIXED_PRE         = 1'b0,
   parameter logic [4:0]       FIXED_PRE_GAIN        = 5'h00,
   parameter logic             USE_FIXED_POST        = 1'b0,
   parameter logic [4:0]       FIXED_POST_GAIN       = 5'h00,
   parameter logic             USE_FIXED_PHASE       = 1'b0,
   parameter logic [7:0]       FIXED_PHASE_OFFSET    = 8'h00,
   parameter logic             INTEG_ENABLE_FROM_PORT = 1'b1,
   parameter logic             FIXED_INTEG_ENABLE    = 1'b1,
   parameter logic             IGNORE_ENABLE         = 1'b0,
   parameter logic             ALLOW_TRACKING_HOLD   = 1'b1,
   parameter int               EXTRA_PHASE_COUNT     = 2,
   parameter int               MAX_SCAN_PICK         = 16,
   parameter logic [15:0]      COEF_PRECISION        = 16'hFFFF,
   parameter logic [15:0]      DET_PRECISION         = 16'hFFFF,
   parameter logic [36:0]      OSC_PRECISION         = 37'h1FFFFFFFFF
) (
   // clock, enable and resets
   input  wire logic                   clk,
   input  wire logic                   rst,
   input  wire logic                   enable,
   input  wire logic                   integralReset,
   // oversampled input
   input  wire logic [`IN_W-1:0]       rawSampleWord,          // see RULE1
   // loop settings
   input  wire logic [`CF_W-1:0]       centerFreq,
   input  wire logic [`GAIN_W-1:0]     directGain,
   input  wire logic [`GAIN_W-1:0]     integralPreGain,
   input  wire logic [`GAIN_W-1:0]     integralPostGain,
   input  wire logic [`PH_W-1:0]       samplingPhaseOffset,
   input  wire logic                   integralPathEnable,
   input  wire logic                   trackingHold,
   // picked bits
   output logic [`MAX_PICK-1:0]        pickedBits,
   output logic [`CNT_W-1:0]           pickedCount,
   // packed words
   output logic [`OUT_W-1:0]           dataWord,
   output logic                        wordValid,
   input  wire logic                   wordReady,
   output logic                        overflow,
   // eye scan
   input  wire logic                   startScan,
   input  wire logic [`PH_W-1:0]       scanPhase0,
   input  wire logic [`PH_W-1:0]       scanPhase1,
   input  wire logic [`SCAN_W-1:0]     scanTime,
   output logic                        scanBusy,
   output logic [`SCAN_W-1:0]          scanErrors0,
   output logic [`SCAN_W-1:0]          scanErrors1
);
   localparam int PW = `OUT_W + `MAX_PICK;
   localparam int FW = $clog2(PW + 1);
   logic                        ce;
   logic [`CF_W-1:0]            centerSel;
   logic [`GAIN_W-1:0]          gDirect;
   logic [`GAIN_W-1:0]          gPre;
   logic [`GAIN_W-1:0]          gPost;
   logic [`PH_W-1:0]            phaseOffset;
   logic                        integOn;
   logic                        hold;
   logic [`CF_W-1:0]            ctrl;
   logic [`FRAC_W-1:0]          phase;
   logic                        lastSample;
   logic signed [`INTEG_W-1:0]  integ;
   logic signed [`INTEG_W-1:0]  corr;
   logic [`ACC_W-1:0]           ph [`IN_W+1];
   logic [`IN_W-1:0]            pick;
   logic [`IN_W-1:0]            edgeAt;
   cdr_pkg::phase_err_t         errSum;
   cdr_pkg::phase_err_t         errTrim;
   logic [`MAX_PICK-1:0]        next_bits;
   logic [`CNT_W-1:0]           next_count;
   // build-time choice between constant and port
   assign ce          = IGNORE_ENABLE ? 1'b1 : enable;                        // see RULE15
   assign centerSel   = USE_FIXED_CENTER ? FIXED_CENTER : centerFreq;         // see RULE11, RULE22
   assign gDirect     = USE_FIXED_DIRECT ? FIXED_DIRECT_GAIN : directGain;     // see RULE12
   assign gPre        = USE_FIXED_PRE ? FIXED_PRE_GAIN : integralPreGain;      // see RULE12
   assign gPost       = USE_FIXED_POST ? FIXED_POST_GAIN : integralPostGain;   // see RULE12
   assign phaseOffset = USE_FIXED_PHASE ? FIXED_PHASE_OFFSET : samplingPhaseOffset; // see RULE13
   assign integOn     = INTEG_ENABLE_FROM_PORT ? integralPathEnable : FIXED_INTEG_ENABLE; // see RULE14
   assign hold        = ALLOW_TRACKING_HOLD && trackingHold;                  // see RULE16
   // oscillator step: centre alone while held
   always_comb begin
      logic signed [`INTEG_W-1:0] raw;
      raw  = $signed({11'h000, centerSel}) - (hold ? '0 : corr);             // see RULE29
      ctrl = raw[`CF_W-1:0] & OSC_PRECISION;                                  // see RULE20
   end
   // per-sample phase, selection and phase detection
   always_comb begin
      logic [`ACC_W-1:0]          c0;
      logic [`ACC_W-1:0]          c1;
      logic [`DET_W-1:0]          frac;
      logic                       prev;
      int                         n;
      c0         = '0;
      c1         = '0;
      frac       = '0;
      prev       = lastSample;
      n          = 0;
      errSum     = '0;
      next_bits  = '0;
      next_count = '0;
      for (int i = 0; i <= `IN_W; i++) begin
         ph[i] = {16'h0000, phase} + `ACC_W'(({11'h000, ctrl} * `ACC_W'(i)) / `ACC_W'(`IN_W));
      end
      for (int i = 0; i < `IN_W; i++) begin
         // bit 0 is the earliest sample
         c0        = ph[i] + `ACC_W'(`HALF_UI) + {16'h0000, phaseOffset, 24'h000000};
         c1        = ph[i+1] + `ACC_W'(`HALF_UI) + {16'h0000, phaseOffset, 24'h000000};
         pick[i]   = (c0[`ACC_W-1:`FRAC_W] != c1[`ACC_W-1:`FRAC_W]);          // see RULE5, RULE2
         edgeAt[i] = (rawSampleWord[i] != prev);
         prev      = rawSampleWord[i];
         frac      = ph[i][`FRAC_W-1:`FRAC_W-`DET_W] & DET_PRECISION;          // see RULE20
         if (edgeAt[i]) begin
            errSum = errSum + `ERR_W'($signed(frac));                          // see RULE3
         end
         if (pick[i] && n < `MAX_PICK) begin                                  // see RULE18
            next_bits[n] = rawSampleWord[i];                                   // see RULE6
            n            = n + 1;
         end
      end
      next_count = `CNT_W'(n);                                                 // see RULE10
   end
   assign errTrim = errSum & $signed({5'h1F, COEF_PRECISION});                 // see RULE20
   // oscillator phase and selector outputs
   always_ff @(posedge clk) begin
      if (rst) begin
         phase       <= '0;
         lastSample  <= 1'b0;
         pickedBits  <= '0;
         pickedCount <= '0;
      end else if (ce) begin                                                   // see RULE26, RULE9
         phase       <= ph[`IN_W][`FRAC_W-1:0];
         lastSample  <= rawSampleWord[`IN_W-1];
         pickedBits  <= next_bits;                                             // see RULE6
         pickedCount <= next_count;                                            // see RULE7
      end
   end
   // direct branch correction plus integral branch output
   always_ff @(posedge clk) begin
      if (rst) begin
         corr <= '0;
      end else if (ce) begin
         corr <= (`INTEG_W'(errTrim) <<< gDirect) + (integ >>> gPost);          // see RULE4
      end
   end

   // integral branch: only its own reset clears it
   always_ff @(posedge clk) begin
      if (integralReset) begin
         integ <= '0;                                                          // see RULE25
      end else if (ce && !rst && integOn && !hold) begin
         integ <= integ + (`INTEG_W'(errTrim) <<< gPre);                       // see RULE4
      end
   end

   // barrel shifter packing, earliest bit lowest
   logic [PW-1:0]     packBits;
   logic [FW-1:0]     packFill;
   logic [PW-1:0]     merged;
   logic [FW-1:0]     total;
   logic              pushValid;
   logic              pushReady;

   assign merged    = packBits | (PW'(pickedBits) << packFill);                // see RULE28
   assign total     = packFill + FW'(pickedCount);
   assign pushValid = ce && (total >= FW'(`OUT_W));

   always_ff @(posedge clk) begin
      if (rst) begin
         packBits <= '0;
         packFill <= '0;
         overflow <= 1'b0;
      end else if (ce) begin
         if (pushValid && pushReady) begin
            packBits <= merged >> `OUT_W;                                      // see RULE8
            packFill <= total - FW'(`OUT_W);
         end else if (pushValid) begin
            overflow <= 1'b1;
         end else begin
            packBits <= merged;
            packFill <= total;
         end
      end
   end

   stream_fifo #(
      .WIDTH (`OUT_W),
      .DEPTH (`FIFO_DEPTH)
   ) u_fifo (
      .clk      (clk),
      .rst      (rst),
      .inValid  (pushValid),
      .inReady  (pushReady),
      .inData   (merged[`OUT_W-1:0]),
      .outValid (wordValid),                                                   // see RULE24
      .outReady (wordReady && ce),
      .outData  (dataWord)
   );

   // live eye scan over the same edges, outside the data path
   cdr_pkg::scan_state_t scanState;
   logic [`SCAN_W-1:0]   scanLeft;
   logic [`SCAN_W-1:0]   errAcc [2];
   logic [`SCAN_W-1:0]   errHit [2];
   logic [`PH_W-1:0]     scanPos [2];
   assign scanPos[0] = scanPhase0;
   assign scanPos[1] = scanPhase1;
   for (genvar p = 0; p < 2; p++) begin : g_phase
      always_comb begin
         logic [`PH_W-1:0] f;
         int               k;
         f         = '0;
         k         = 0;
         errHit[p] = '0;
         for (int i = 0; i < `IN_W; i++) begin
            f = ph[i][`FRAC_W-1:`FRAC_W-`PH_W];
            if (edgeAt[i] && p < EXTRA_PHASE_COUNT && k < MAX_SCAN_PICK) begin // see RULE17, RULE19
               k = k + 1;
               if (scanPos[p] >= `PH_MID ? (f >= `PH_MID && f <= scanPos[p])
                                         : (f >= scanPos[p] && f < `PH_MID)) begin
                  errHit[p] = errHit[p] + `SCAN_W'(1);
               end
            end
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst || EXTRA_PHASE_COUNT == 0) begin
         scanState   <= cdr_pkg::SCAN_IDLE;
         scanBusy    <= 1'b0;
         scanLeft    <= '0;
         errAcc[0]   <= '0;
         errAcc[1]   <= '0;
         scanErrors0 <= '0;
         scanErrors1 <= '0;
      end else if (ce) begin
         unique case (scanState)
            cdr_pkg::SCAN_IDLE: begin
               if (startScan) begin                                            // see RULE27
                  scanState <= cdr_pkg::SCAN_RUN;
                  scanBusy  <= 1'b1;
                  scanLeft  <= scanTime;
                  errAcc[0] <= '0;
                  errAcc[1] <= '0;
               end
            end
            cdr_pkg::SCAN_RUN: begin
               errAcc[0] <= errAcc[0] + errHit[0];                             // see RULE21
               errAcc[1] <= errAcc[1] + errHit[1];
               scanLeft  <= scanLeft - `SCAN_W'(1);
               if (scanLeft == '0) begin
                  scanState   <= cdr_pkg::SCAN_IDLE;
                  scanBusy    <= 1'b0;
                  scanErrors0 <= errAcc[0] + errHit[0];
                  scanErrors1 <= errAcc[1] + errHit[1];
               end
            end
         endcase
      end
   end

   // checks
   property p_count_max;
      @(posedge clk) disable iff (rst) pickedCount <= `CNT_W'(`MAX_PICK);
   endproperty
   a_count_max: assert property (p_count_max) else $error("picked count above limit"); // see RULE10
   property p_bits_low;
      @(posedge clk) disable iff (rst) (pickedBits >> pickedCount) == '0;
   endproperty
   a_bits_low: assert property (p_bits_low) else $error("picked bits not in low positions"); // see RULE6
   property p_hold_freq;
      @(posedge clk) disable iff (rst) hold |-> ctrl == (centerSel & OSC_PRECISION);
   endproperty
   a_hold_freq: assert property (p_hold_freq) else $error("held oscillator not at centre"); // see RULE29
   property p_integ_survive;
      @(posedge clk) disable iff (integralReset) rst |=> $stable(integ);
   endproperty
   a_integ_survive: assert property (p_integ_survive) else $error("main reset moved integral"); // see RULE25
   property p_integ_off;
      @(posedge clk) disable iff (integralReset) !integOn |=> $stable(integ);
   endproperty
   a_integ_off: assert property (p_integ_off) else $error("integral moved while disabled"); // see RULE14
   property p_fill_bound;
      @(posedge clk) disable iff (rst) packFill < FW'(`OUT_W);
   endproperty
   a_fill_bound: assert property (p_fill_bound) else $error("packer holds a full word"); // see RULE8
   property p_ce_freeze;
      @(posedge clk) disable iff (rst) !ce |=> $stable(phase) && $stable(packFill) && $stable(corr);
   endproperty
   a_ce_freeze: assert property (p_ce_freeze) else $error("state moved with enable low"); // see RULE26
   property p_word_stand;
      @(posedge clk) disable iff (rst) wordValid && !(wordReady && ce) |=> wordValid && $stable(dataWord);
   endproperty
   a_word_stand: assert property (p_word_stand) else $error("unaccepted word changed"); // see RULE24
   property p_scan_ignore;
      @(posedge clk) disable iff (rst) scanBusy && ce && scanLeft != '0 ##0 startScan
         |=> scanLeft == $past(scanLeft) - `SCAN_W'(1);
   endproperty
   a_scan_ignore: assert property (p_scan_ignore) else $error("scan restarted while busy"); // see RULE27
   c_word_out: cover property (@(posedge clk) disable iff (rst) wordValid && wordReady);
   c_hold: cover property (@(posedge clk) disable iff (rst) hold && pickedCount != '0);
   c_scan_done: cover property (@(posedge clk) disable iff (rst) $fell(scanBusy));
   c_two_bits: cover property (@(posedge clk) disable iff (rst) pickedCount == `CNT_W'(2));
endmodule

/* test/oversampled_data_recovery_tb.sv */
// self-checking bench for the oversampled data recovery block
`timescale 1ns/10ps
`include "cdr_consts.svh"

module oversampled_data_recovery_tb;
   logic clk = 1'b0, rst = 1'b1, enable = 1'b1, integralReset = 1'b1;
   logic [`CF_W-1:0] centerFreq = 37'h0500000000;
   logic trackingHold = 1'b0, wordReady = 1'b1, startScan = 1'b0, integralPathEnable = 1'b1;
   logic [`PH_W-1:0] scanPhase0 = 8'h00, scanPhase1 = 8'hFF, samplingPhaseOffset = 8'h00;
   logic [`SCAN_W-1:0] scanTime = 16'h0014;
   logic [`IN_W-1:0] rawSampleWord;
   logic [`MAX_PICK-1:0] pickedBits;
   logic [`CNT_W-1:0] pickedCount;
   logic [`OUT_W-1:0] dataWord;
   logic wordValid, overflow, scanBusy;
   logic [`SCAN_W-1:0] scanErrors0, scanErrors1;
   int n_mismatch = 0, num_checks = 0, cycles = 0;
   logic seq [127];

   always #10 clk = ~clk;

   sample_source #(.SPB(4)) src (.clk(clk), .rst(rst), .advance(enable),
      .rawSampleWord(rawSampleWord));

   oversampled_data_recovery uut (.clk(clk), .rst(rst), .enable(enable),
      .integralReset(integralReset), .rawSampleWord(rawSampleWord),
      .centerFreq(centerFreq), .directGain(5'h0B), .integralPreGain(5'h02),
      .integralPostGain(5'h0C), .samplingPhaseOffset(samplingPhaseOffset),
      .integralPathEnable(integralPathEnable), .trackingHold(trackingHold),
      .pickedBits(pickedBits), .pickedCount(pickedCount), .dataWord(dataWord),
      .wordValid(wordValid), .wordReady(wordReady), .overflow(overflow),
      .startScan(startScan), .scanPhase0(scanPhase0), .scanPhase1(scanPhase1),
      .scanTime(scanTime), .scanBusy(scanBusy), .scanErrors0(scanErrors0),
      .scanErrors1(scanErrors1));

   task automatic check(input string name, input logic [63:0] seen, input logic [63:0] exp);
      num_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("mismatch %s expected %0h seen %0h", name, exp, seen);
      end
   endtask

   task automatic stop_test();
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   always @(posedge clk) begin
      cycles++;
      if (cycles == 5000) begin
         n_mismatch++;
         stop_test();
      end
   end

   task automatic test_reset();
      check("pickedCount rst", pickedCount, 0);
      check("wordValid rst", wordValid, 0);
      check("overflow rst", overflow, 0);
      check("scanBusy rst", scanBusy, 0);
      check("scanErrors rst", {scanErrors0, scanErrors1}, 0);
   endtask

   // sums picked bits over n cycles and compares with the expected total
   task automatic rate_bits(input int n, input int exp);
      int sum;
      sum = 0;
      repeat (n) begin
         @(negedge clk);
         sum += pickedCount;
         check("pickedCount limit", pickedCount <= 7'h0A, 1);
         check("pickedBits upper", pickedBits >> pickedCount, 0);
      end
      check("bit rate", sum >= exp - 3 && sum <= exp + 3, 1);
   endtask

   // aligns on the first word, then follows the pattern word by word
   task automatic test_data();
      int k;
      logic [`OUT_W-1:0] e;
      k = -1;
      repeat (60) begin
         @(negedge clk);
         if (wordValid === 1'b1) begin
            if (k < 0) begin
               for (int c = 0; c < 127; c++) begin
                  for (int j = 0; j < `OUT_W; j++) e[j] = seq[(c + j) % 127];
                  if (e === dataWord) k = (c + `OUT_W) % 127;
               end
            end else begin
               for (int j = 0; j < `OUT_W; j++) e[j] = seq[(k + j) % 127];
               check("dataWord", dataWord, e);
               k = (k + `OUT_W) % 127;
            end
         end
      end
      check("word aligned", k >= 0, 1);
   endtask

   task automatic test_hold();
      @(posedge clk);
      centerFreq <= 37'h04FB000000;
      trackingHold <= 1'b1;
      repeat (50) @(posedge clk);
      rate_bits(512, 2550);
      @(posedge clk);
      trackingHold <= 1'b0;
      repeat (300) @(posedge clk);
      rate_bits(512, 2560);
      @(posedge clk);
      centerFreq <= 37'h0500000000;
      repeat (300) @(posedge clk);
   endtask

   task automatic test_enable();
      logic [37:0] held;
      @(posedge clk);
      enable <= 1'b0;
      @(negedge clk);
      held = {pickedBits, pickedCount, dataWord, wordValid};
      repeat (10) begin
         @(negedge clk);
         check("frozen outputs", {pickedBits, pickedCount, dataWord, wordValid}, held);
      end
      @(posedge clk);
      enable <= 1'b1;
   endtask

   task automatic test_fifo();
      logic [`OUT_W-1:0] head;
      @(posedge clk);
      wordReady <= 1'b0;
      repeat (3) @(negedge clk);
      head = dataWord;
      repeat (40) begin
         @(negedge clk);
         check("wordValid stall", wordValid, 1);
         check("dataWord stall", dataWord, head);
      end
      check("overflow full", overflow, 1);
      @(posedge clk);
      wordReady <= 1'b1;
      rst <= 1'b1;
      @(posedge clk);
      rst <= 1'b0;
      @(negedge clk);
      check("overflow cleared", overflow, 0);
      check("wordValid cleared", wordValid, 0);
      repeat (300) @(posedge clk);
   endtask

   // a second start during the scan must not stretch it
   task automatic test_scan();
      int busy, sum;
      busy = 0;
      sum = 0;
      for (int i = 0; i < 45; i++) begin
         @(posedge clk);
         startScan <= (i == 0 || i == 6);
         integralPathEnable <= (i == 44);
         @(negedge clk);
         busy += scanBusy;
         sum += pickedCount;
         if (i == 1) check("scanBusy start", scanBusy, 1);
      end
      check("scan length", busy, 21);
      check("scan rate", sum >= 222 && sum <= 228, 1);
      check("scan errors", (scanErrors0 + scanErrors1) != 0, 1);
   endtask

   initial begin
      logic [6:0] l;
      l = 7'h7F;
      for (int n = 0; n < 127; n++) begin
         seq[n] = l[0];
         l = {l[5:0], l[6] ^ l[5]};
      end
      repeat (3) @(posedge clk);
      @(negedge clk);
      test_reset();
      @(posedge clk);
      rst <= 1'b0;
      integralReset <= 1'b0;
      repeat (300) @(posedge clk);
      test_data();
      test_hold();
      test_data();
      test_enable();
      test_fifo();
      @(posedge clk);
      samplingPhaseOffset <= 8'h20;
      repeat (20) @(posedge clk);
      test_data();
      test_scan();
      stop_test();
   end
endmodule

/* test/sample_source.sv */
// deserializer model delivering oversampled words of a repeating bit pattern
`timescale 1ns/10ps
`include "cdr_consts.svh"

// runs from the core clock only, as a reference-locked deserializer
module sample_source #(
   parameter int SPB = 4
) (
   // clock and control
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic        advance,
   // oversampled word
   output logic [`IN_W-1:0] rawSampleWord
);
   logic [6:0]      lfsr;
   logic [`IN_W-1:0] w;
   int              sub;

   initial rawSampleWord = '0;

   always @(posedge clk) begin
      if (rst) begin
         lfsr = 7'h7F;
         sub = 0;
      end else if (advance) begin
         for (int i = 0; i < `IN_W; i++) begin
            w[i] = lfsr[0];
            sub++;
            if (sub == SPB) begin
               sub = 0;
               lfsr = {lfsr[5:0], lfsr[6] ^ lfsr[5]};
            end
         end
         rawSampleWord <= w;
      end
   end
endmodule
